/* File: hdl/eps_map.svh */
// Named constants for the engine parameter sampler
`ifndef EPS_MAP_SVH
`define EPS_MAP_SVH
`define EPS_CLK_HZ 25000000
`define EPS_TICK_MS 20
`define EPS_TICK_CYC ((`EPS_TICK_MS * `EPS_CLK_HZ) / 1000)
`define EPS_PAIR_US 100
`define EPS_PAIR_CYC ((`EPS_PAIR_US * `EPS_CLK_HZ) / 1000000)
`define EPS_SPEED_TMO_MS 1000
`define EPS_SPEED_TMO_CYC ((`EPS_SPEED_TMO_MS * `EPS_CLK_HZ) / 1000)
`define EPS_RPM_SEC 32'h00000078
`define EPS_REV_DEG 42'h00000002D0
`define EPS_LEAN_LIM 16'h0064
`define EPS_RICH_LIM 16'h09C4
`define EPS_SPK_MIN 17'h1FFC4
`define EPS_SPK_MAX 17'h0001E
`define EPS_SPK_WIN 17'h0003C
`define EPS_SPK_SENT 16'h001F
`define EPS_PPR_WIN 8'h08
`define EPS_REC_MIN_TICKS 17'h00001
`define EPS_REC_MAX_TICKS 17'h15F90
`define EPS_DSK_MIN_TICKS 17'h00005
`define EPS_DSK_MAX_TICKS 17'h00BB8
`define EPS_FAST_LOG2 3'h0
`define EPS_FAST_IVL 8'h01
`define EPS_P_AFR 0
`define EPS_P_MAP 1
`define EPS_P_RPM 2
`define EPS_P_SPK 3
`define EPS_F_LEAN 0
`define EPS_F_RICH 1
`define EPS_F_MAPLO 2
`define EPS_F_MAPHI 3
`define EPS_F_RPMLO 4
`define EPS_F_RPMHI 5
`define EPS_F_SPK 6
`endif

/* File: hdl/eps_pkg.sv */
// Types shared by the engine parameter sampler
package eps_pkg;
  typedef logic [3:0][15:0] eps_vals_t;
  typedef struct packed {
    logic [6:0] flags;
    eps_vals_t val;
  } eps_sample_t;
  typedef enum logic [1:0] {
    EPS_IDLE = 2'b00,
    EPS_RPM = 2'b01,
    EPS_SPK = 2'b11
  } eps_calc_t;
endpackage : eps_pkg

/* File: hdl/eps_stream_if.sv */
// Valid/ready sample stream between sampler parts
`timescale 1ns/1ps
interface eps_stream_if;
  logic valid;
  logic ready;
  eps_pkg::eps_sample_t data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : eps_stream_if

/* File: hdl/eps_skid.sv */
// Small FIFO buffer for sample words
`timescale 1ns/1ps
module eps_skid #(
  parameter int DEPTH = 2
) (
  input wire logic clock,
  input wire logic reset_n,
  eps_stream_if.snk up,
  eps_stream_if.src dn
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  eps_pkg::eps_sample_t mem_r [DEPTH];
  logic [PW-1:0] wr_r;
  logic [PW-1:0] rd_r;
  logic [PW:0] cnt_r;
  logic push;
  logic pop;

  assign up.ready = (cnt_r != (PW+1)'(DEPTH));
  assign dn.valid = (cnt_r != '0);
  assign dn.data = mem_r[rd_r];
  assign push = up.valid && up.ready;
  assign pop = dn.valid && dn.ready;

  always_ff @(posedge clock)
  begin
    if (push)
      mem_r[wr_r] <= up.data;
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (push)
        wr_r <= (wr_r == PW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
      if (pop)
        rd_r <= (rd_r == PW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
      cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  chk_skid_hold: assert property (@(posedge clock) disable iff (!reset_n)
    dn.valid && !dn.ready |=> dn.valid && $stable(dn.data))
    else $error("Buffered word changed while stalled");
endmodule : eps_skid

/* File: hdl/eps_div.sv */
// Sequential restoring divider
`timescale 1ns/1ps
module eps_div #(
  parameter int W = 32
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic start,
  input wire logic [W-1:0] num,
  input wire logic [W-1:0] den,
  output logic busy,
  output logic done,
  output logic [W-1:0] quot
);
  logic [W:0] rem_r;
  logic [W:0] tmp;
  logic [W-1:0] den_r;
  logic [W-1:0] num_r;
  logic [$clog2(W+1)-1:0] cnt_r;

  assign tmp = {rem_r[W-1:0], quot[W-1]};

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rem_r <= '0;
      quot <= '0;
      den_r <= '0;
      num_r <= '0;
      cnt_r <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start && !busy)
      begin
        rem_r <= '0;
        quot <= num;
        num_r <= num;
        den_r <= den;
        cnt_r <= ($clog2(W+1))'(W);
        busy <= 1'b1;
      end
      else if (busy)
      begin
        if (tmp >= {1'b0, den_r})
        begin
          rem_r <= tmp - {1'b0, den_r};
          quot <= {quot[W-2:0], 1'b1};
        end
        else
        begin
          rem_r <= tmp;
          quot <= {quot[W-2:0], 1'b0};
        end
        cnt_r <= cnt_r - 1'b1;
        if (cnt_r == 1)
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

  chk_div_exact: assert property (@(posedge clock) disable iff (!reset_n)
    done && den_r != '0 |-> ((2*W)'(quot) * (2*W)'(den_r) <= (2*W)'(num_r)) &&
      ((2*W)'(quot + 1'b1) * (2*W)'(den_r) > (2*W)'(num_r)))
    else $error("Quotient does not match dividend and divisor");
endmodule : eps_div

/* File: hdl/eps_sampler.sv */
// Engine parameter sampler: tick capture, limits, averaging, decimation, statistics
// Summary of operation
// - Capture all four parameters once per 20 ms tick.
// - Ratio and pressure are taken within 100 us of each other.
// - Ratio, pressure live; speed, spark hold until a new calculation completes or the speed timeout zeroes speed and marks spark missing.
// - Display shows averages; sample count and refresh interval are selectable.
// - Host live stream uses the fastest averaging and refresh setting.
// - Recording keeps every Nth unaveraged tick, interval 0.02 s to 30 min.
// - Disk stream delivers unaveraged ticks every 0.1 s to 60 s.
// - Ratio below 0.1 flags lean, above 2.5 flags rich, shown as indicator.
// - Out-of-range ratio is recorded and streamed as the lean or rich limit.
// - Speed and pressure saturate to nearest limit everywhere.
// - Missing or out-of-range spark records and streams 31, display shows dash.
// - Statistics give average, deviation, maximum and minimum per parameter.
// - Statistics include substituted limit and sentinel values.
// - Speed comes from edge period scaled by pulses per two revolutions.
// - Spark valid range -60 to 30, or 60-degree window above eight pulses.
`timescale 1ns/1ps
`include "eps_map.svh"
module eps_sampler #(
  parameter int unsigned TICK_CYCLES = `EPS_TICK_CYC,
  parameter int unsigned SPEED_TIMEOUT = `EPS_SPEED_TMO_CYC,
  parameter logic [15:0] MAP_MIN = 16'h0000,
  parameter logic [15:0] MAP_MAX = 16'h7FFF,
  parameter logic [15:0] RPM_MIN = 16'h0000,
  parameter logic [15:0] RPM_MAX = 16'h3A98
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [15:0] ratio_in,
  input wire logic [15:0] pressure_in,
  input wire logic speed_edge,
  input wire logic spark_edge,
  input wire logic [7:0] pulses_per_2rev,
  input wire logic [15:0] edge_angle,
  input wire logic [15:0] spk_win_start,
  input wire logic [2:0] avg_log2,
  input wire logic [7:0] disp_interval,
  input wire logic rec_enable,
  input wire logic [16:0] rec_interval,
  input wire logic disk_enable,
  input wire logic [16:0] disk_interval,
  input wire logic rec_ready,
  input wire logic disk_ready,
  input wire logic stat_clear,
  output logic tick,
  output logic sample_valid,
  output eps_pkg::eps_sample_t sample,
  output eps_pkg::eps_vals_t disp_val,
  output logic [6:0] disp_flags,
  output logic disp_update,
  output eps_pkg::eps_vals_t host_val,
  output logic [6:0] host_flags,
  output logic host_update,
  output logic rec_valid,
  output eps_pkg::eps_sample_t rec_data,
  output logic rec_overrun,
  output logic disk_valid,
  output eps_pkg::eps_sample_t disk_data,
  output logic disk_overrun,
  output logic [23:0] stat_count,
  output wire logic [3:0][39:0] stat_sum,
  output wire logic [3:0][47:0] stat_sumsq,
  output wire logic [3:0][15:0] stat_max,
  output wire logic [3:0][15:0] stat_min
);
  logic [31:0] tick_cnt_r;
  logic [31:0] per_cnt_r;
  logic [31:0] t_rpm_r;
  logic [31:0] t_spk_r;
  logic [31:0] tspk_lat_r;
  logic edge_seen_r;
  logic spk_seen_r;
  logic spk_ok_r;
  logic spk_miss_r;
  logic spk_bad_r;
  logic [15:0] rpm_calc_r;
  logic [15:0] spk_calc_r;
  eps_pkg::eps_calc_t st_r;
  logic [31:0] t_sel;
  logic [39:0] den_full;
  logic [41:0] spk_full;
  logic div_start;
  logic [31:0] div_num;
  logic [31:0] div_den;
  logic div_busy;
  logic div_done;
  logic [31:0] div_quot;
  logic wide_win;
  logic signed [16:0] spk_raw;
  logic signed [16:0] win_lo;
  logic signed [16:0] win_hi;
  eps_pkg::eps_sample_t smp_r;
  logic smp_vld_r;
  logic [1:0] push;
  logic [1:0] out_ready;
  logic [1:0] ovr_r;
  eps_pkg::eps_vals_t avg_out_r [2];
  logic [6:0] avg_flg_r [2];
  logic avg_upd_r [2];
  logic [16:0] ivl_cnt_r [2];

  // Measurement time base
  assign tick = (tick_cnt_r == TICK_CYCLES - 1);
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      tick_cnt_r <= '0;
    else
      tick_cnt_r <= tick ? '0 : tick_cnt_r + 1'b1;
  end

  // Edge period and spark delay measurement
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      per_cnt_r <= '0;
      edge_seen_r <= 1'b0;
      spk_seen_r <= 1'b0;
      t_spk_r <= '0;
    end
    else if (speed_edge)
    begin
      per_cnt_r <= 32'h00000001;
      edge_seen_r <= 1'b1;
      spk_seen_r <= 1'b0;
    end
    else
    begin
      if (per_cnt_r != 32'hFFFFFFFF)
        per_cnt_r <= per_cnt_r + 1'b1;
      if (spark_edge && edge_seen_r && !spk_seen_r)
      begin
        spk_seen_r <= 1'b1;
        t_spk_r <= per_cnt_r;
      end
    end
  end

  assign t_sel = (st_r == eps_pkg::EPS_IDLE) ? per_cnt_r : t_rpm_r;
  assign den_full = 40'(t_sel) * 40'(pulses_per_2rev);
  assign spk_full = 42'(tspk_lat_r) * `EPS_REV_DEG;
  assign div_den = (den_full[39:32] != '0) ? 32'hFFFFFFFF : den_full[31:0];
  assign div_num = (st_r == eps_pkg::EPS_IDLE) ?
    (`EPS_RPM_SEC * 32'(`EPS_CLK_HZ)) :
    ((spk_full[41:32] != '0) ? 32'hFFFFFFFF : spk_full[31:0]);
  assign div_start = ((st_r == eps_pkg::EPS_IDLE) && speed_edge && edge_seen_r) ||
    ((st_r == eps_pkg::EPS_RPM) && div_done && spk_ok_r);

  eps_div #(.W(32)) u_div (
    .clock(clock),
    .reset_n(reset_n),
    .start(div_start),
    .num(div_num),
    .den(div_den),
    .busy(div_busy),
    .done(div_done),
    .quot(div_quot)
  );

  assign wide_win = (pulses_per_2rev > `EPS_PPR_WIN);
  assign win_lo = wide_win ? 17'(signed'(spk_win_start)) : `EPS_SPK_MIN;
  assign win_hi = wide_win ? (win_lo + `EPS_SPK_WIN) : `EPS_SPK_MAX;
  assign spk_raw = 17'(signed'(edge_angle)) + 17'(div_quot[15:0]);

  // Speed and spark calculation sequence
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_r <= eps_pkg::EPS_IDLE;
      t_rpm_r <= '0;
      tspk_lat_r <= '0;
      spk_ok_r <= 1'b0;
      spk_miss_r <= 1'b1;
      spk_bad_r <= 1'b0;
      rpm_calc_r <= '0;
      spk_calc_r <= `EPS_SPK_SENT;
    end
    else
    begin
      case (st_r)
        eps_pkg::EPS_IDLE:
        begin
          if (div_start)
          begin
            t_rpm_r <= per_cnt_r;
            tspk_lat_r <= t_spk_r;
            spk_ok_r <= spk_seen_r;
            st_r <= eps_pkg::EPS_RPM;
          end
          else if (per_cnt_r >= SPEED_TIMEOUT)
          begin
            rpm_calc_r <= '0;
            spk_miss_r <= 1'b1;
          end
        end
        eps_pkg::EPS_RPM:
        begin
          if (div_done)
          begin
            rpm_calc_r <= (div_quot[31:16] != '0) ? 16'hFFFF : div_quot[15:0];
            spk_miss_r <= !spk_ok_r;
            st_r <= spk_ok_r ? eps_pkg::EPS_SPK : eps_pkg::EPS_IDLE;
          end
        end
        eps_pkg::EPS_SPK:
        begin
          if (div_done)
          begin
            spk_calc_r <= spk_raw[15:0];
            spk_bad_r <= (div_quot[31:15] != '0) || (spk_raw < win_lo) ||
              (spk_raw > win_hi);
            st_r <= eps_pkg::EPS_IDLE;
          end
        end
        default:
          st_r <= eps_pkg::EPS_IDLE;
      endcase
    end
  end

  // Tick capture with limit substitution and flags
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      smp_r <= '0;
      smp_vld_r <= 1'b0;
    end
    else
    begin
      smp_vld_r <= tick;
      if (tick)
      begin
        smp_r.val[`EPS_P_AFR] <= (ratio_in < `EPS_LEAN_LIM) ? `EPS_LEAN_LIM :
          (ratio_in > `EPS_RICH_LIM) ? `EPS_RICH_LIM : ratio_in;
        smp_r.val[`EPS_P_MAP] <= (pressure_in < MAP_MIN) ? MAP_MIN :
          (pressure_in > MAP_MAX) ? MAP_MAX : pressure_in;
        smp_r.val[`EPS_P_RPM] <= (rpm_calc_r < RPM_MIN) ? RPM_MIN :
          (rpm_calc_r > RPM_MAX) ? RPM_MAX : rpm_calc_r;
        smp_r.val[`EPS_P_SPK] <= (spk_miss_r || spk_bad_r) ? `EPS_SPK_SENT :
          spk_calc_r;
        smp_r.flags[`EPS_F_LEAN] <= (ratio_in < `EPS_LEAN_LIM);
        smp_r.flags[`EPS_F_RICH] <= (ratio_in > `EPS_RICH_LIM);
        smp_r.flags[`EPS_F_MAPLO] <= (pressure_in < MAP_MIN);
        smp_r.flags[`EPS_F_MAPHI] <= (pressure_in > MAP_MAX);
        smp_r.flags[`EPS_F_RPMLO] <= (rpm_calc_r < RPM_MIN);
        smp_r.flags[`EPS_F_RPMHI] <= (rpm_calc_r > RPM_MAX);
        smp_r.flags[`EPS_F_SPK] <= spk_miss_r || spk_bad_r;
      end
    end
  end
  assign sample = smp_r;
  assign sample_valid = smp_vld_r;

  // Averagers: index 0 is the display, index 1 the fast host stream
  for (genvar a = 0; a < 2; a++)
  begin : g_avg
    logic [2:0] lg;
    logic [7:0] iv;
    logic [7:0] n_r;
    logic [7:0] rf_r;
    logic signed [23:0] acc_r [4];
    logic signed [23:0] sum_w [4];
    eps_pkg::eps_vals_t hold_r;
    assign lg = (a == 0) ? avg_log2 : `EPS_FAST_LOG2;
    assign iv = (a == 0) ? ((disp_interval == '0) ? 8'h01 : disp_interval) :
      `EPS_FAST_IVL;
    always_comb
    begin
      for (int p = 0; p < 4; p++)
        sum_w[p] = acc_r[p] + 24'(signed'(smp_r.val[p]));
    end
    always_ff @(posedge clock or negedge reset_n)
    begin
      if (!reset_n)
      begin
        n_r <= '0;
        hold_r <= '0;
        for (int p = 0; p < 4; p++)
          acc_r[p] <= '0;
      end
      else if (smp_vld_r)
      begin
        if (n_r == 8'((9'h001 << lg) - 9'h001))
        begin
          n_r <= '0;
          for (int p = 0; p < 4; p++)
          begin
            hold_r[p] <= 16'(sum_w[p] >>> lg);
            acc_r[p] <= '0;
          end
        end
        else
        begin
          n_r <= n_r + 1'b1;
          for (int p = 0; p < 4; p++)
            acc_r[p] <= sum_w[p];
        end
      end
    end
    always_ff @(posedge clock or negedge reset_n)
    begin
      if (!reset_n)
      begin
        rf_r <= '0;
        avg_out_r[a] <= '0;
        avg_flg_r[a] <= '0;
        avg_upd_r[a] <= 1'b0;
      end
      else
      begin
        avg_upd_r[a] <= 1'b0;
        if (smp_vld_r)
        begin
          if (rf_r >= iv - 1'b1)
          begin
            rf_r <= '0;
            avg_out_r[a] <= (lg == 3'h0) ? smp_r.val : hold_r;
            avg_flg_r[a] <= smp_r.flags;
            avg_upd_r[a] <= 1'b1;
          end
          else
            rf_r <= rf_r + 1'b1;
        end
      end
    end
  end
  assign disp_val = avg_out_r[0];
  assign disp_flags = avg_flg_r[0];
  assign disp_update = avg_upd_r[0];
  assign host_val = avg_out_r[1];
  assign host_flags = avg_flg_r[1];
  assign host_update = avg_upd_r[1];

  // Decimated unaveraged streams: index 0 recording, index 1 disk
  eps_stream_if s_up [2] ();
  eps_stream_if s_dn [2] ();
  assign out_ready = {disk_ready, rec_ready};
  for (genvar s = 0; s < 2; s++)
  begin : g_str
    logic en;
    logic [16:0] raw;
    logic [16:0] ivl;
    assign en = (s == 0) ? rec_enable : disk_enable;
    assign raw = (s == 0) ? rec_interval : disk_interval;
    assign ivl = (s == 0) ?
      ((raw < `EPS_REC_MIN_TICKS) ? `EPS_REC_MIN_TICKS :
       (raw > `EPS_REC_MAX_TICKS) ? `EPS_REC_MAX_TICKS : raw) :
      ((raw < `EPS_DSK_MIN_TICKS) ? `EPS_DSK_MIN_TICKS :
       (raw > `EPS_DSK_MAX_TICKS) ? `EPS_DSK_MAX_TICKS : raw);
    assign push[s] = smp_vld_r && en && (ivl_cnt_r[s] == '0);
    always_ff @(posedge clock or negedge reset_n)
    begin
      if (!reset_n)
        ivl_cnt_r[s] <= '0;
      else if (!en)
        ivl_cnt_r[s] <= '0;
      else if (smp_vld_r)
        ivl_cnt_r[s] <= (ivl_cnt_r[s] >= ivl - 1'b1) ? '0 : ivl_cnt_r[s] + 1'b1;
    end
    always_ff @(posedge clock or negedge reset_n)
    begin
      if (!reset_n)
        ovr_r[s] <= 1'b0;
      else if (push[s] && !s_up[s].ready)
        ovr_r[s] <= 1'b1;
      else if (!en)
        ovr_r[s] <= 1'b0;
    end
    assign s_up[s].valid = push[s];
    assign s_up[s].data = smp_r;
    assign s_dn[s].ready = out_ready[s];
    eps_skid #(.DEPTH(2)) u_buf (
      .clock(clock),
      .reset_n(reset_n),
      .up(s_up[s]),
      .dn(s_dn[s])
    );
  end
  assign rec_valid = s_dn[0].valid;
  assign rec_data = s_dn[0].data;
  assign disk_valid = s_dn[1].valid;
  assign disk_data = s_dn[1].data;
  assign rec_overrun = ovr_r[0];
  assign disk_overrun = ovr_r[1];

  // Statistics over the recorded data set, substituted values included
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      stat_count <= '0;
    else if (stat_clear)
      stat_count <= '0;
    else if (push[0] && stat_count != 24'hFFFFFF)
      stat_count <= stat_count + 1'b1;
  end
  for (genvar p = 0; p < 4; p++)
  begin : g_stat
    logic signed [15:0] sv;
    logic signed [39:0] sum_r;
    logic [47:0] sq_r;
    logic signed [15:0] max_r;
    logic signed [15:0] min_r;
    assign sv = signed'(smp_r.val[p]);
    always_ff @(posedge clock or negedge reset_n)
    begin
      if (!reset_n)
      begin
        sum_r <= '0;
        sq_r <= '0;
        max_r <= 16'sh8000;
        min_r <= 16'sh7FFF;
      end
      else if (stat_clear)
      begin
        sum_r <= '0;
        sq_r <= '0;
        max_r <= 16'sh8000;
        min_r <= 16'sh7FFF;
      end
      else if (push[0])
      begin
        sum_r <= sum_r + 40'(sv);
        sq_r <= sq_r + 48'(32'(sv * sv));
        max_r <= (sv > max_r) ? sv : max_r;
        min_r <= (sv < min_r) ? sv : min_r;
      end
    end
    assign stat_sum[p] = sum_r;
    assign stat_sumsq[p] = sq_r;
    assign stat_max[p] = max_r;
    assign stat_min[p] = min_r;
  end

  // Checks
  logic [31:0] gap_r;
  logic tick_seen_r;
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      gap_r <= '0;
      tick_seen_r <= 1'b0;
    end
    else
    begin
      gap_r <= tick ? '0 : gap_r + 1'b1;
      tick_seen_r <= tick_seen_r | tick;
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  chk_tick_period: assert property (tick && tick_seen_r |-> gap_r == TICK_CYCLES - 1)
    else $error("Tick spacing wrong");
  chk_pair_capture: assert property (tick && ratio_in >= `EPS_LEAN_LIM &&
    ratio_in <= `EPS_RICH_LIM && pressure_in >= MAP_MIN && pressure_in <= MAP_MAX |=>
    smp_r.val[`EPS_P_AFR] == $past(ratio_in) && smp_r.val[`EPS_P_MAP] == $past(pressure_in))
    else $error("Ratio and pressure not captured together");
  chk_hold_between: assert property (!tick |=> $stable(smp_r))
    else $error("Sample changed between ticks");
  chk_lean_limit: assert property (tick && ratio_in < `EPS_LEAN_LIM |=>
    smp_r.val[`EPS_P_AFR] == `EPS_LEAN_LIM && smp_r.flags[`EPS_F_LEAN])
    else $error("Lean ratio not substituted");
  chk_rich_limit: assert property (tick && ratio_in > `EPS_RICH_LIM |=>
    smp_r.val[`EPS_P_AFR] == `EPS_RICH_LIM && smp_r.flags[`EPS_F_RICH])
    else $error("Rich ratio not substituted");
  chk_map_sat: assert property (tick && pressure_in > MAP_MAX |=>
    smp_r.val[`EPS_P_MAP] == MAP_MAX && smp_r.flags[`EPS_F_MAPHI])
    else $error("Pressure not saturated");
  chk_spk_sentinel: assert property (smp_vld_r && smp_r.flags[`EPS_F_SPK] |->
    smp_r.val[`EPS_P_SPK] == `EPS_SPK_SENT)
    else $error("Spark sentinel missing");
  chk_rec_restart: assert property ($rose(rec_enable) |-> ivl_cnt_r[0] == '0)
    else $error("Record decimation did not restart");
  chk_rec_decim: assert property (push[0] |=> !push[0] [*2])
    else $error("Recording pushed twice within a tick");
  chk_stat_order: assert property (stat_count != '0 && !stat_clear |->
    signed'(stat_max[`EPS_P_AFR]) >= signed'(stat_min[`EPS_P_AFR]))
    else $error("Statistics maximum below minimum");
endmodule : eps_sampler

/* File: verif/eps_front_model.sv */
// Speed and spark pickup model with stream receivers
`timescale 1ns/1ps
module eps_front_model (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [15:0] period,
  input wire logic [15:0] delay,
  input wire logic stall,
  output logic speed_edge,
  output logic spark_edge,
  output logic rec_ready,
  output logic disk_ready
);
  logic [15:0] cnt_r;
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      cnt_r <= 16'h0000;
    else if (cnt_r + 16'h0001 >= period)
      cnt_r <= 16'h0000;
    else
      cnt_r <= cnt_r + 16'h0001;
  end
  // Period zero keeps both pickups quiet
  assign speed_edge = (period != 16'h0000) && (cnt_r == 16'h0000);
  assign spark_edge = (period != 16'h0000) && (cnt_r == delay);
  assign rec_ready = !stall;
  assign disk_ready = !stall;
endmodule : eps_front_model

/* File: verif/engine_param_sampler_tb_top.sv */
// Self-checking bench for the engine parameter sampler
`timescale 1ns/1ps
module engine_param_sampler_tb_top;
  logic clock, reset_n, speed_edge, spark_edge, rec_ready, disk_ready;
  logic rec_enable, disk_enable, stat_clear, stall;
  logic sample_valid, disp_update, host_update, rec_valid, rec_overrun, disk_valid, disk_overrun;
  logic [15:0] ratio_in, pressure_in, edge_angle, spk_win_start, period, delay;
  logic [7:0] pulses_per_2rev, disp_interval;
  logic [2:0] avg_log2;
  logic [16:0] rec_interval, disk_interval;
  logic [23:0] stat_count;
  logic [3:0][15:0] stat_max, stat_min;
  logic [3:0][39:0] stat_sum;
  logic [3:0][47:0] stat_sumsq;
  logic [6:0] disp_flags, host_flags;
  logic tick;
  eps_pkg::eps_sample_t sample, rec_data, disk_data, rec_got, disk_got;
  eps_pkg::eps_vals_t host_val, disp_val;
  int mismatches, checks_done, n;
  int c[4];
  eps_sampler #(.TICK_CYCLES(50), .SPEED_TIMEOUT(6000)) dut (
    .clock, .reset_n, .ratio_in, .pressure_in, .speed_edge, .spark_edge,
    .pulses_per_2rev, .edge_angle, .spk_win_start, .avg_log2, .disp_interval,
    .rec_enable, .rec_interval, .disk_enable, .disk_interval, .rec_ready,
    .disk_ready, .stat_clear, .tick, .sample_valid, .sample, .disp_val,
    .disp_flags, .disp_update, .host_val, .host_flags, .host_update,
    .rec_valid, .rec_data, .rec_overrun, .disk_valid, .disk_data, .disk_overrun,
    .stat_count, .stat_sum, .stat_sumsq, .stat_max, .stat_min);
  eps_front_model peer (.clock, .reset_n, .period, .delay, .stall, .speed_edge,
    .spark_edge, .rec_ready, .disk_ready);
  task automatic report_and_stop;
    $display("mismatches=%0d checks_done=%0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // Waits for the next sample; n gets the cycles waited
  task automatic wait_sv;
    n = 0;
    do
    begin
      @(negedge clock);
      n++;
      if (n > 300)
      begin
        mismatches++;
        report_and_stop();
      end
    end
    while (sample_valid !== 1'b1);
  endtask : wait_sv
  // Counts record pops, disk pops, display and host updates
  task automatic run_cnt(input int cyc);
    c = '{0, 0, 0, 0};
    repeat (cyc)
    begin
      @(negedge clock);
      c[0] += int'(rec_valid & rec_ready);
      c[1] += int'(disk_valid & disk_ready);
      c[2] += int'(disp_update);
      c[3] += int'(host_update);
      if (rec_valid & rec_ready)
        rec_got = rec_data;
      if (disk_valid & disk_ready)
        disk_got = disk_data;
    end
  endtask : run_cnt
  task automatic sc_tick;
    wait_sv();
    chk(sample.val[3], 16'h001F);
    chk(sample.flags[6], 1'b1);
    wait_sv();
    chk(48'(n), 48'h32);
    repeat (49) @(negedge clock);
    chk(tick, 1'b1);
  endtask : sc_tick
  task automatic sc_limits;
    logic [15:0] t[4][5];
    t = '{'{16'h0032, 16'h1234, 16'h0064, 16'h1234, 16'h0001},
      '{16'h0BB8, 16'h8000, 16'h09C4, 16'h7FFF, 16'h000A},
      '{16'h03E8, 16'h0100, 16'h03E8, 16'h0100, 16'h0000},
      '{16'h0064, 16'h7FFF, 16'h0064, 16'h7FFF, 16'h0000}};
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clock);
      ratio_in <= t[i][0];
      pressure_in <= t[i][1];
      wait_sv();
      wait_sv();
      chk(sample.val[0], t[i][2]);
      chk(sample.val[1], t[i][3]);
      chk(sample.flags[3:0], t[i][4][3:0]);
    end
  endtask : sc_limits
  task automatic sc_speed;
    @(posedge clock);
    pulses_per_2rev <= 8'h64;
    edge_angle <= 16'hFFF6;
    spk_win_start <= 16'hFFE2;
    delay <= 16'h04E2;
    period <= 16'h0BB8;
    repeat (250) wait_sv();
    chk(sample.val[2], 16'h2710);
    chk(sample.val[3], 16'hFFF9);
    chk(sample.flags[6:4], 3'h0);
  endtask : sc_speed
  task automatic sc_display;
    @(posedge clock);
    avg_log2 <= 3'h1;
    disp_interval <= 8'h02;
    repeat (3) wait_sv();
    run_cnt(400);
    chk(48'(c[2]), 48'h4);
    chk(48'(c[3]), 48'h8);
    chk(host_val[1], pressure_in);
    chk(disp_val[1], pressure_in);
  endtask : sc_display
  task automatic sc_record;
    @(posedge clock);
    ratio_in <= 16'h0032;
    stat_clear <= 1'b1;
    @(posedge clock);
    stat_clear <= 1'b0;
    rec_enable <= 1'b1;
    disk_enable <= 1'b1;
    run_cnt(450);
    chk(48'(c[0]), 48'h3);
    chk(48'(c[1]), 48'h2);
    chk(rec_got.val[0], 16'h0064);
    chk(disk_got.val[0], 16'h0064);
    chk(rec_got.flags[0], 1'b1);
    chk(disp_val[0], 16'h0064);
    chk(disp_flags, 7'h01);
    chk(host_flags, 7'h01);
    chk(stat_count, 24'h000003);
    chk(stat_sum[0], 40'h000000012C);
    chk(stat_sumsq[0], 48'h000000007530);
    chk(stat_min[0], 16'h0064);
    chk(stat_max[0], 16'h0064);
  endtask : sc_record
  task automatic sc_stall;
    @(posedge clock);
    rec_interval <= 17'h00001;
    stall <= 1'b1;
    repeat (4) wait_sv();
    chk(rec_overrun, 1'b1);
    @(posedge clock);
    rec_enable <= 1'b0;
    disk_enable <= 1'b0;
    stall <= 1'b0;
    run_cnt(10);
    chk(48'(c[0]), 48'h2);
    chk(rec_valid, 1'b0);
    chk(rec_overrun, 1'b0);
  endtask : sc_stall
  task automatic sc_ranges;
    @(posedge clock);
    edge_angle <= 16'h0028;
    repeat (70) wait_sv();
    chk(sample.val[3], 16'h001F);
    chk(sample.flags[6], 1'b1);
    @(posedge clock);
    pulses_per_2rev <= 8'h08;
    edge_angle <= 16'hFFC4;
    repeat (70) wait_sv();
    chk(sample.val[2], 16'h3A98);
    chk(sample.flags[5], 1'b1);
    chk(sample.val[3], 16'hFFE9);
    chk(sample.flags[6], 1'b0);
  endtask : sc_ranges
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial
  begin
    {rec_enable, disk_enable, stat_clear, stall} = 4'h0;
    {ratio_in, pressure_in, edge_angle, spk_win_start} = 64'h03E8_0100_0000_0000;
    {period, delay, pulses_per_2rev, avg_log2, disp_interval} = 51'h0;
    rec_interval = 17'h00003;
    disk_interval = 17'h00005;
    reset_n = 1'b0;
    repeat (6) @(posedge clock);
    reset_n <= 1'b1;
    @(negedge clock);
    chk(stat_max[0], 16'h8000);
    chk(stat_min[0], 16'h7FFF);
    sc_tick();
    sc_limits();
    sc_speed();
    sc_display();
    sc_record();
    sc_stall();
    sc_ranges();
    report_and_stop();
  end
endmodule : engine_param_sampler_tb_top
